// [core/comparator_map.vh]
`ifndef COMPARATOR_MAP_VH
`define COMPARATOR_MAP_VH

// register byte offsets on the axi4-lite bus (low address bits)
`define CMP_ADDR_CTRL0 4'h0
`define CMP_ADDR_CTRL1 4'h4
`define CMP_ADDR_REFCTL 4'h8
`define CMP_ADDR_IRQCTL 4'hC

// comparator_control_0 fields
`define CMP_C0_ON 7
`define CMP_C0_RESULT 6
`define CMP_C0_PIN_DRIVE 5
`define CMP_C0_INVERT 4
`define CMP_C0_REF_SEL 2
`define CMP_C0_CHANNEL 0
`define CMP_C0_WMASK 8'hB5
`define CMP_C0_RESET 8'h00

// comparator_control_1 fields
`define CMP_C1_FAST_CLK 4
`define CMP_C1_HYST 3
`define CMP_C1_GATE_SRC 1
`define CMP_C1_SYNC 0
`define CMP_C1_WMASK 8'h1B
`define CMP_C1_RESET 8'h02

// reference_control_reg fields
`define CMP_RC_LADDER_EN 7
`define CMP_RC_RANGE 5
`define CMP_RC_FIXED_EN 4
`define CMP_RC_LEVEL_HI 3
`define CMP_RC_WMASK 8'hBF
`define CMP_RC_RESET 8'h00

// change flag and interrupt enable register fields
`define CMP_IR_FLAG 0
`define CMP_IR_CHANGE_EN 1
`define CMP_IR_PERIPH_EN 2
`define CMP_IR_GLOBAL_EN 3
`define CMP_IR_WMASK 8'h0F
`define CMP_IR_RESET 8'h00

// axi responses
`define CMP_RESP_OKAY 2'h0
`define CMP_RESP_SLVERR 2'h2

// instruction cycle is four system clocks
`define CMP_PHASE_LAST 2'h3
`define CMP_PHASE_Q1 2'h0

// ladder fraction of supply: low range code/24, high range (8+code)/32
`define CMP_LAD_DEN_LOW 6'h18
`define CMP_LAD_DEN_HIGH 6'h20
`define CMP_LAD_HIGH_BASE 6'h08

`endif

// [core/ladder_level_rom.v]
`timescale 1ns/1ps
`include "comparator_map.vh"

// registered lookup of the ladder tap as a fraction of supply
module ladder_level_rom (
  input wire aclk,
  input wire aresetn,
  input wire range_low,
  input wire [3:0] level_code,
  output reg [5:0] frac_num,
  output reg [5:0] frac_den
);

  // fraction updates one clock after the code changes
  always @(posedge aclk) begin
    if (!aresetn) begin
      frac_num <= 6'h00;
      frac_den <= `CMP_LAD_DEN_HIGH;
    end else if (range_low) begin
      frac_num <= {2'h0, level_code};
      frac_den <= `CMP_LAD_DEN_LOW;
    end else begin
      // quarter supply is 8/32, so the steps stack above it
      frac_num <= `CMP_LAD_HIGH_BASE + {2'h0, level_code};
      frac_den <= `CMP_LAD_DEN_HIGH;
    end
  end

endmodule // ladder_level_rom

// [core/comparator_control_logic.v]
`timescale 1ns/1ps
`include "comparator_map.vh"

// Function
// - change during register read may drop flag
// - enabled comparator keeps running in sleep
// - clearing on bit switches comparator off
// - change wakes sleep with both enables set
// - service routine only with global enable
// - reset restores control registers, everything off
// - control0 bit7 enables comparator, resets zero
// - control0 bit6 reads result, polarity applied
// - pin drive needs enable, on, output direction
// - control0 bit4 inverts result
// - control0 bit2 picks reference or plus pin
// - control0 bit0 picks minus input pin
// - unimplemented control bits read zero
// - control1 bit1 gate source, resets one
// - sync latches on timer clock falling edge
// - control1 bit0 enables result synchronisation
// - control1 bit4 selects fast timer clock
// - control1 bit3 enables hysteresis
// - ladder has two ranges, sixteen levels
// - ladder levels follow range formulas
// - ladder enable independent of comparator
// - control0 read or write captures reference latch
// - flag set on mismatch edge, software clears
module comparator_control_logic #(
  parameter ADDR_W = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire analog_compare_raw,
  input wire timer_clock_in,
  input wire timer_gate_pin,
  input wire pin_direction_output,
  output reg comparator_on,
  output reg plus_input_ref_select,
  output reg minus_input_channel,
  output reg hysteresis_enable,
  output reg timer_fast_clock_select,
  output reg ladder_enable,
  output reg fixed_ref_enable,
  output wire [5:0] ladder_frac_num,
  output wire [5:0] ladder_frac_den,
  output reg result_pin_out,
  output reg result_pin_oe_n,
  output reg timer_gate_out,
  output reg wake_request,
  output reg interrupt_request
);

  // software visible storage, only writable bits are kept
  reg [7:0] comparator_control_0_r; // enable, pin drive, polarity, input selects
  reg [7:0] comparator_control_1_r; // timer clock, hysteresis, gate source, sync
  reg [7:0] reference_control_reg_r; // ladder enable, range, fixed ref, level
  reg [7:0] irq_control_r; // change flag and the three enables

  // bus slave state
  reg aw_have_r; // write address held
  reg w_have_r; // write data held
  reg [ADDR_W-1:0] aw_addr_r;
  reg [7:0] w_byte_r; // low byte of write data
  reg w_lane_r; // low byte lane strobed

  // synchronisers and mismatch circuit
  reg raw_s1_r;
  reg raw_s2_r;
  reg tclk_s1_r;
  reg tclk_s2_r;
  reg tclk_s3_r; // previous synced timer clock, for the falling edge
  reg gate_s1_r;
  reg gate_s2_r;
  reg sync_latch_r; // result latched on timer clock fall
  reg [1:0] phase_r; // instruction cycle phase, 0 is q1
  reg live_latch_r; // updated once per instruction cycle
  reg ref_latch_r; // updated on control0 access
  reg mismatch_d_r; // previous mismatch, for edge detection

  wire write_fire;
  wire read_fire;
  wire async_result;
  wire cur_result;
  wire mismatch;
  wire mismatch_rise;
  wire ctrl0_access;

  // only the four word offsets decode; others answer slverr
  function addr_hit;
    input [ADDR_W-1:0] a;
    begin
      addr_hit = (a == `CMP_ADDR_CTRL0) || (a == `CMP_ADDR_CTRL1) ||
                 (a == `CMP_ADDR_REFCTL) || (a == `CMP_ADDR_IRQCTL);
    end
  endfunction

  // read value of a register, zero above the low byte
  function [31:0] reg_value;
    input [ADDR_W-1:0] a;
    input [7:0] c0;
    input [7:0] c1;
    input [7:0] rc;
    input [7:0] ir;
    input res;
    begin
      case (a)
        `CMP_ADDR_CTRL0: reg_value = {24'h000000, c0[7], res, c0[5:0]};
        `CMP_ADDR_CTRL1: reg_value = {24'h000000, c1};
        `CMP_ADDR_REFCTL: reg_value = {24'h000000, rc};
        `CMP_ADDR_IRQCTL: reg_value = {24'h000000, ir};
        default: reg_value = 32'h00000000;
      endcase
    end
  endfunction

  // write completes once both halves are held and no response is pending
  assign write_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign read_fire = s_axi_arvalid && s_axi_arready;

  // a write includes a read, so both refresh the reference latch
  assign ctrl0_access = (read_fire && (s_axi_araddr == `CMP_ADDR_CTRL0)) ||
                        (write_fire && (aw_addr_r == `CMP_ADDR_CTRL0));

  // polarity applied; an off comparator reads low
  assign async_result = comparator_control_0_r[`CMP_C0_ON] &&
                        (raw_s2_r ^ comparator_control_0_r[`CMP_C0_INVERT]);
  assign cur_result = comparator_control_1_r[`CMP_C1_SYNC] ? sync_latch_r : async_result;

  assign mismatch = live_latch_r ^ ref_latch_r;
  assign mismatch_rise = mismatch && !mismatch_d_r;

  // address and data channels, taken independently
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= {ADDR_W{1'b0}};
      w_byte_r <= 8'h00;
      w_lane_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMP_RESP_OKAY;
    end else begin
      // readies drop while a beat is held or a response waits
      s_axi_awready <= !aw_have_r && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_r && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_byte_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
      if (write_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_hit(aw_addr_r) ? `CMP_RESP_OKAY : `CMP_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CMP_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !read_fire;
      if (read_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= reg_value(s_axi_araddr, comparator_control_0_r, comparator_control_1_r,
                                 reference_control_reg_r, irq_control_r, cur_result);
        s_axi_rresp <= addr_hit(s_axi_araddr) ? `CMP_RESP_OKAY : `CMP_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // control registers; a write without the low lane stores nothing
  always @(posedge aclk) begin
    if (!aresetn) begin
      comparator_control_0_r <= `CMP_C0_RESET;
      comparator_control_1_r <= `CMP_C1_RESET;
      reference_control_reg_r <= `CMP_RC_RESET;
    end else if (write_fire && w_lane_r) begin
      case (aw_addr_r)
        `CMP_ADDR_CTRL0: comparator_control_0_r <= w_byte_r & `CMP_C0_WMASK;
        `CMP_ADDR_CTRL1: comparator_control_1_r <= w_byte_r & `CMP_C1_WMASK;
        `CMP_ADDR_REFCTL: reference_control_reg_r <= w_byte_r & `CMP_RC_WMASK;
        default: begin
          // other offsets hold nothing here
        end
      endcase
    end
  end

  // flag and enables; a hardware set beats a software clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_control_r <= `CMP_IR_RESET;
    end else begin
      if (write_fire && w_lane_r && (aw_addr_r == `CMP_ADDR_IRQCTL)) begin
        irq_control_r <= w_byte_r & `CMP_IR_WMASK;
      end
      if (mismatch_rise) begin
        irq_control_r[`CMP_IR_FLAG] <= 1'b1;
      end
    end
  end

  // two flops on every input from outside the clock domain
  always @(posedge aclk) begin
    if (!aresetn) begin
      raw_s1_r <= 1'b0;
      raw_s2_r <= 1'b0;
      tclk_s1_r <= 1'b0;
      tclk_s2_r <= 1'b0;
      tclk_s3_r <= 1'b0;
      gate_s1_r <= 1'b0;
      gate_s2_r <= 1'b0;
    end else begin
      raw_s1_r <= analog_compare_raw;
      raw_s2_r <= raw_s1_r;
      tclk_s1_r <= timer_clock_in;
      tclk_s2_r <= tclk_s1_r;
      tclk_s3_r <= tclk_s2_r;
      gate_s1_r <= timer_gate_pin;
      gate_s2_r <= gate_s1_r;
    end
  end

  // latch on the falling edge of the post-prescaler timer clock,
  // half a period clear of the rising edge on which the timer counts
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_latch_r <= 1'b0;
    end else if (tclk_s3_r && !tclk_s2_r) begin
      sync_latch_r <= async_result;
    end
  end

  // instruction cycle phase counter
  always @(posedge aclk) begin
    if (!aresetn) begin
      phase_r <= `CMP_PHASE_Q1;
    end else if (phase_r == `CMP_PHASE_LAST) begin
      phase_r <= `CMP_PHASE_Q1;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // mismatch latches; a change landing with a control0 access in q1 is
  // taken by both latches at once and raises no edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      live_latch_r <= 1'b0;
      ref_latch_r <= 1'b0;
      mismatch_d_r <= 1'b0;
    end else begin
      if (phase_r == `CMP_PHASE_Q1) begin
        live_latch_r <= cur_result;
      end
      if (ctrl0_access) begin
        ref_latch_r <= cur_result;
      end
      mismatch_d_r <= mismatch;
    end
  end

  // analog controls, held even while the core sleeps
  always @(posedge aclk) begin
    if (!aresetn) begin
      comparator_on <= 1'b0;
      plus_input_ref_select <= 1'b0;
      minus_input_channel <= 1'b0;
      hysteresis_enable <= 1'b0;
      timer_fast_clock_select <= 1'b0;
      ladder_enable <= 1'b0;
      fixed_ref_enable <= 1'b0;
    end else begin
      comparator_on <= comparator_control_0_r[`CMP_C0_ON];
      plus_input_ref_select <= comparator_control_0_r[`CMP_C0_REF_SEL];
      minus_input_channel <= comparator_control_0_r[`CMP_C0_CHANNEL];
      hysteresis_enable <= comparator_control_1_r[`CMP_C1_HYST];
      timer_fast_clock_select <= comparator_control_1_r[`CMP_C1_FAST_CLK];
      ladder_enable <= reference_control_reg_r[`CMP_RC_LADDER_EN];
      fixed_ref_enable <= reference_control_reg_r[`CMP_RC_FIXED_EN];
    end
  end

  // pin, timer gate and wake outputs, all registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      result_pin_out <= 1'b0;
      result_pin_oe_n <= 1'b1;
      timer_gate_out <= 1'b0;
      wake_request <= 1'b0;
      interrupt_request <= 1'b0;
    end else begin
      result_pin_out <= cur_result;
      // pin direction comes from core logic on this clock
      result_pin_oe_n <= !(comparator_control_0_r[`CMP_C0_PIN_DRIVE] &&
                           comparator_control_0_r[`CMP_C0_ON] && pin_direction_output);
      // gate source resets to the external pin
      timer_gate_out <= comparator_control_1_r[`CMP_C1_GATE_SRC] ? gate_s2_r : cur_result;
      wake_request <= irq_control_r[`CMP_IR_FLAG] && irq_control_r[`CMP_IR_CHANGE_EN] &&
                      irq_control_r[`CMP_IR_PERIPH_EN];
      // the core runs the next instruction before vectoring
      interrupt_request <= irq_control_r[`CMP_IR_FLAG] && irq_control_r[`CMP_IR_CHANGE_EN] &&
                           irq_control_r[`CMP_IR_PERIPH_EN] && irq_control_r[`CMP_IR_GLOBAL_EN];
    end
  end

  // ladder tap fraction; range bit set means the low range
  ladder_level_rom u_ladder (
    .aclk(aclk),
    .aresetn(aresetn),
    .range_low(reference_control_reg_r[`CMP_RC_RANGE]),
    .level_code(reference_control_reg_r[`CMP_RC_LEVEL_HI:0]),
    .frac_num(ladder_frac_num),
    .frac_den(ladder_frac_den)
  );

endmodule // comparator_control_logic

// [dv/comparator_control_logic_props.sv]
`timescale 1ns/1ps
// port-level relations of the comparator control block
module cmp_ctrl_props (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire comparator_on,
  input wire ladder_enable,
  input wire [5:0] ladder_frac_num,
  input wire [5:0] ladder_frac_den,
  input wire result_pin_oe_n,
  input wire wake_request,
  input wire interrupt_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a response may not vanish or change before it is taken
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken while response pending");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  // registers are one byte wide, upper bits never carry data
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  irq_wake_a: assert property (interrupt_request |-> wake_request)
    else $error("interrupt without wake condition");
  reset_off_a: assert property ($rose(aresetn) |-> !comparator_on && !ladder_enable && result_pin_oe_n)
    else $error("outputs not off after reset");
  // rom output lags reset by one clock, so skip the first edge
  ladder_span_a: assert property ($past(aresetn) |-> (ladder_frac_den == 6'h18 && ladder_frac_num <= 6'h0F)
    || (ladder_frac_den == 6'h20 && ladder_frac_num >= 6'h08 && ladder_frac_num <= 6'h17))
    else $error("ladder fraction out of range");
endmodule // cmp_ctrl_props

bind comparator_control_logic cmp_ctrl_props cmp_ctrl_props_i (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .comparator_on,
  .ladder_enable, .ladder_frac_num, .ladder_frac_den, .result_pin_oe_n, .wake_request, .interrupt_request);

// [dv/test_comparator_control_logic.sv]
`timescale 1ns/1ps
// self-checking bench: registers over axi4-lite, pins driven directly
module test_comparator_control_logic;
  reg aclk = 0, aresetn = 0;
  reg [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  reg [31:0] s_axi_wdata = 0;
  reg [3:0] s_axi_wstrb = 0;
  reg analog_compare_raw = 0, timer_clock_in = 0, timer_gate_pin = 0, pin_direction_output = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire comparator_on, plus_input_ref_select, minus_input_channel, hysteresis_enable, timer_fast_clock_select;
  wire ladder_enable, fixed_ref_enable, result_pin_out, result_pin_oe_n, timer_gate_out;
  wire wake_request, interrupt_request;
  wire [5:0] ladder_frac_num, ladder_frac_den;
  integer fail_count = 0, check_count = 0, i;

  // 5-bit address leaves 0x10 unmapped
  comparator_control_logic #(.ADDR_W(5)) comparator_control_logic_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .analog_compare_raw, .timer_clock_in, .timer_gate_pin, .pin_direction_output,
    .comparator_on, .plus_input_ref_select, .minus_input_channel, .hysteresis_enable, .timer_fast_clock_select,
    .ladder_enable, .fixed_ref_enable, .ladder_frac_num, .ladder_frac_den, .result_pin_out, .result_pin_oe_n,
    .timer_gate_out, .wake_request, .interrupt_request);

  // 100 mhz clock
  always #5 aclk = ~aclk;

  task chk(input string nm, input [31:0] e, input [31:0] g);
    check_count = check_count + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task tick(input integer n);
    repeat (n) @(posedge aclk);
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input [4:0] a, input [7:0] d, input [3:0] s, input [1:0] er);
    reg ad, wd;
    begin
      ad = 0;
      wd = 0;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s; s_axi_wvalid <= 1; s_axi_bready <= 1;
      while (!ad || !wd) begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) begin ad = 1; s_axi_awvalid <= 0; end
        if (s_axi_wvalid && s_axi_wready) begin wd = 1; s_axi_wvalid <= 0; end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk("bresp", er, s_axi_bresp);
    end
  endtask

  // read and compare one register
  task automatic rchk(input [4:0] a, input [7:0] e, input [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk("rresp", er, s_axi_rresp);
    chk("rdata", {24'h0, e}, s_axi_rdata);
  endtask

  task t_reset;
    rchk(5'h00, 8'h00, 2'h0);
    rchk(5'h04, 8'h02, 2'h0);
    rchk(5'h08, 8'h00, 2'h0);
    rchk(5'h0C, 8'h00, 2'h0);
  endtask

  // every control0 bit, result with and without inversion
  task t_ctrl;
    wr(5'h00, 8'hFF, 4'hF, 2'h0);
    tick(12);
    rchk(5'h00, 8'hF5, 2'h0);
    chk("c0 outs", 3'b111, {comparator_on, plus_input_ref_select, minus_input_channel});
    chk("pin out", 1, result_pin_out);
    analog_compare_raw <= 1;
    tick(12);
    rchk(5'h00, 8'hB5, 2'h0);
    chk("pin out", 0, result_pin_out);
    wr(5'h00, 8'h80, 4'hF, 2'h0);
    tick(12);
    rchk(5'h00, 8'hC0, 2'h0);
    chk("c0 outs", 3'b100, {comparator_on, plus_input_ref_select, minus_input_channel});
    wr(5'h00, 8'h00, 4'hF, 2'h0);
    tick(12);
    rchk(5'h00, 8'h00, 2'h0);
    wr(5'h04, 8'hFF, 4'hF, 2'h0);
    rchk(5'h04, 8'h1B, 2'h0);
    chk("c1 outs", 2'b11, {hysteresis_enable, timer_fast_clock_select});
    wr(5'h04, 8'h00, 4'h0, 2'h0);
    rchk(5'h04, 8'h1B, 2'h0);
    wr(5'h04, 8'h02, 4'hF, 2'h0);
    rchk(5'h04, 8'h02, 2'h0);
    chk("c1 outs", 2'b00, {hysteresis_enable, timer_fast_clock_select});
  endtask

  // pin drive needs all three of drive, on and output direction
  task t_pin;
    for (i = 0; i < 8; i = i + 1) begin
      wr(5'h00, {i[1], 1'b0, i[2], 5'h0}, 4'hF, 2'h0);
      pin_direction_output <= i[0];
      tick(6);
      chk("oe_n", i != 7, result_pin_oe_n);
    end
  endtask

  // both ranges, every level code, with the comparator left on
  task t_ladder;
    for (i = 0; i < 32; i = i + 1) begin
      wr(5'h08, {2'b10, i[4], 1'b0, i[3:0]}, 4'hF, 2'h0);
      tick(3);
      chk("num", i[4] ? i[3:0] : 8 + i[3:0], ladder_frac_num);
      chk("den", i[4] ? 24 : 32, ladder_frac_den);
      chk("ladder on", 1, ladder_enable);
    end
    wr(5'h08, 8'hFF, 4'hF, 2'h0);
    rchk(5'h08, 8'hBF, 2'h0);
    wr(5'h08, 8'h10, 4'hF, 2'h0);
    tick(3);
    chk("refs", 2'b01, {ladder_enable, fixed_ref_enable});
  endtask

  // flag is edge triggered, reference latch follows control0 reads
  task t_flag;
    analog_compare_raw <= 0;
    wr(5'h00, 8'h80, 4'hF, 2'h0);
    tick(12);
    wr(5'h0C, 8'h06, 4'hF, 2'h0);
    rchk(5'h0C, 8'h06, 2'h0);
    analog_compare_raw <= 1;
    tick(12);
    rchk(5'h0C, 8'h07, 2'h0);
    chk("wake irq", 2'b10, {wake_request, interrupt_request});
    rchk(5'h00, 8'hC0, 2'h0);
    wr(5'h0C, 8'h0E, 4'hF, 2'h0);
    tick(12);
    rchk(5'h0C, 8'h0E, 2'h0);
    analog_compare_raw <= 0;
    tick(12);
    rchk(5'h0C, 8'h0F, 2'h0);
    chk("wake irq", 2'b11, {wake_request, interrupt_request});
    wr(5'h0C, 8'h08, 4'hF, 2'h0);
    rchk(5'h0C, 8'h08, 2'h0);
    wr(5'h0C, 8'h09, 4'hF, 2'h0);
    rchk(5'h0C, 8'h09, 2'h0);
    tick(3);
    chk("wake irq", 2'b00, {wake_request, interrupt_request});
    wr(5'h0C, 8'h00, 4'hF, 2'h0);
  endtask

  // gate source and falling-edge synchronisation of the result
  task t_gate;
    timer_gate_pin <= 1;
    tick(6);
    chk("gate", 1, timer_gate_out);
    timer_gate_pin <= 0;
    tick(6);
    chk("gate", 0, timer_gate_out);
    wr(5'h04, 8'h01, 4'hF, 2'h0);
    timer_clock_in <= 1;
    tick(6);
    timer_clock_in <= 0;
    tick(8);
    chk("gate", 0, timer_gate_out);
    analog_compare_raw <= 1;
    tick(10);
    chk("gate", 0, timer_gate_out);
    timer_clock_in <= 1;
    tick(8);
    chk("gate", 0, timer_gate_out);
    timer_clock_in <= 0;
    tick(8);
    chk("gate", 1, timer_gate_out);
    wr(5'h04, 8'h00, 4'hF, 2'h0);
    analog_compare_raw <= 0;
    tick(10);
    chk("gate", 0, timer_gate_out);
  endtask

  // unmapped place answers with an error and reads zero
  task t_unmapped;
    rchk(5'h10, 8'h00, 2'h2);
    wr(5'h10, 8'hFF, 4'hF, 2'h2);
  endtask

  task wrap_up;
    if (fail_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    tick(5);
    aresetn <= 1;
    t_reset;
    t_ctrl;
    t_pin;
    t_ladder;
    t_flag;
    t_gate;
    t_unmapped;
    wrap_up;
  end

  // watchdog well beyond the expected run length
  initial begin
    #200000;
    fail_count = fail_count + 1;
    wrap_up;
  end
endmodule // test_comparator_control_logic
